// File: shared/ifunc_pkg.sv
package ifunc_pkg;

    // ----------------------------------------------------------------
    // primary addressing
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_MAX      = 5'h1e;   // highest usable primary address
    localparam logic [2:0] GRP_LISTEN    = 3'h1;    // bits 6:5 = 01 listen group
    localparam logic [2:0] GRP_TALK      = 3'h2;    // bits 6:5 = 10 talk group
    localparam int         GRP_POS       = 5;       // group field position
    localparam logic [4:0] ADDR_UNASSIGN = 5'h1f;   // unlisten / untalk code

    // ----------------------------------------------------------------
    // interface command codes (seven bits, parity bit ignored)
    // ----------------------------------------------------------------
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;

    // ----------------------------------------------------------------
    // status byte layout and reset values
    // ----------------------------------------------------------------
    localparam int         RSV_BIT    = 6;          // request-service bit in status byte
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int         FIFO_DEPTH = 8;
    localparam int         DATA_W     = 8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRIG_CONT,
        get_trigger_mode_first,
        get_trigger_mode_second,
        TRIG_OTHER
    } trig_mode_t;

    // logical levels: 1 means the line is asserted (true)
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
        logic       atn;
        logic       ren;
        logic       ifc;
        logic       srq;
    } bus_in_t;

    // lines this end may pull; ATN, IFC and REN are never among them
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
        logic       srq;
    } bus_drv_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } tx_word_t;

endpackage

// File: verilog/rx_fifo.sv
`timescale 1ns/100ps
module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and control
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } fifo_st_t;

    fifo_st_t r;
    fifo_st_t next_r;
    logic     push;
    logic     pop;
    logic     room;

    // the prefetched output word counts toward depth, so the buffer holds DEPTH words in all
    assign room = (r.cnt + CW'(r.ov)) != CW'(DEPTH);

    // ----------------------------------------------------------------
    // next state: output word is prefetched into a register
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        push   = in_valid && room;
        pop    = (r.cnt != '0) && (!r.ov || out_ready);
        if (r.ov && out_ready) begin
            next_r.ov = 1'b0;
        end
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp        = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            next_r.od = r.mem[r.rp];
            next_r.ov = 1'b1;
            next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign in_ready  = room;
    assign out_valid = r.ov;
    assign out_data  = r.od;

endmodule // rx_fifo

// File: verilog/bus_ifunc.sv
`timescale 1ns/100ps
module bus_ifunc
    import ifunc_pkg::*;
#(
    parameter int FIFO_W = ifunc_pkg::DATA_W,
    parameter int FIFO_D = ifunc_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ce,
    // bus lines: sampled level, driven level, enable
    input  wire ifunc_pkg::bus_in_t      bus_in,
    output ifunc_pkg::bus_drv_t          bus_out,
    output ifunc_pkg::bus_drv_t          bus_oe,
    // configuration
    input  wire logic [4:0]              primary_addr,
    input  wire logic                    talk_only,
    input  wire ifunc_pkg::trig_mode_t   trig_mode,
    // outgoing data from the instrument
    input  wire logic                    tx_valid,
    input  wire ifunc_pkg::tx_word_t     tx_word,
    output logic                         tx_ready,
    // received device-dependent data
    output logic                         rx_valid,
    output logic [FIFO_W-1:0]            rx_data,
    input  wire logic                    rx_ready,
    // service request and status
    input  wire logic                    service_req,
    input  wire logic [7:0]              status_byte,
    // front panel
    input  wire logic                    panel_local,
    output logic                         panel_enable,
    // state and events
    output logic                         talk_addressed,
    output logic                         listen_addressed,
    output logic                         remote,
    output logic                         lockout,
    output logic                         dev_clear,
    output logic                         reading_start
);
    import ifunc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {AH_IDLE, AH_NRDY, AH_READY, AH_DONE} ah_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SETUP, SH_DAV, SH_HOLD}  sh_t;

    typedef struct packed {
        ah_t        ah;
        sh_t        sh;
        logic       tads;
        logic       lads;
        logic       spms;
        logic       rem;
        logic       llo;
        logic       srq_pend;
        logic       push;
        logic [7:0] rx_byte;
        logic       poll_byte;
        logic       tx_done;
        bus_drv_t   drv;
        bus_drv_t   oe;
        logic       clr;
        logic       trig;
        logic       pnl;
    } st_t;

    st_t  r;
    st_t  next_r;
    logic fifo_in_ready;

    // ----------------------------------------------------------------
    // received data buffer
    // ----------------------------------------------------------------
    rx_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_rx_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (r.push),
        .in_data   (FIFO_W'(r.rx_byte)),
        .in_ready  (fifo_in_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    logic       addr_ok;
    logic       acc_on;
    logic       src_on;
    logic [6:0] cmd;
    logic       is_mla;
    logic       is_mta;
    logic       is_ota;
    logic       is_unl;
    logic       is_unt;

    // address out of range never matches, so the device stays unaddressed
    always_comb begin
        addr_ok = (primary_addr <= ADDR_MAX);
        cmd     = bus_in.dio[6:0];
        is_mla  = addr_ok && (cmd == {GRP_LISTEN[1:0], primary_addr});
        is_mta  = addr_ok && (cmd == {GRP_TALK[1:0], primary_addr});
        is_ota  = (cmd[6:GRP_POS] == GRP_TALK[1:0]) && !is_mta
                  && (cmd[4:0] != ADDR_UNASSIGN);
        is_unl  = (cmd == {GRP_LISTEN[1:0], ADDR_UNASSIGN});
        is_unt  = (cmd == {GRP_TALK[1:0], ADDR_UNASSIGN});
        // acceptor joins in for every command and for data when listening
        acc_on  = bus_in.atn || r.lads;
        // source only runs while ATN is false
        src_on  = !bus_in.atn && (r.tads || talk_only);
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.push    = 1'b0;
        next_r.tx_done = 1'b0;
        next_r.clr     = 1'b0;
        next_r.trig    = 1'b0;
        // parallel poll and controller lines are simply not in bus_drv_t
        next_r.oe.srq  = 1'b0;

        // ---- acceptor handshake ----
        case (r.ah)
            AH_IDLE: begin
                next_r.oe.nrfd = 1'b0;
                next_r.oe.ndac = 1'b0;
                if (acc_on) begin
                    next_r.ah      = AH_NRDY;
                    next_r.oe.nrfd = 1'b1;
                    next_r.oe.ndac = 1'b1;
                end
            end
            AH_NRDY: begin
                // data byte waits for buffer room; back-pressure holds NRFD
                if (!acc_on) begin
                    next_r.ah = AH_IDLE;
                end else if (bus_in.atn || fifo_in_ready) begin
                    next_r.ah      = AH_READY;
                    next_r.oe.nrfd = 1'b0;
                end
            end
            AH_READY: begin
                if (!acc_on) begin
                    next_r.ah = AH_IDLE;
                end else if (!bus_in.atn && !fifo_in_ready) begin
                    next_r.ah      = AH_NRDY;
                    next_r.oe.nrfd = 1'b1;
                end else if (bus_in.dav) begin
                    next_r.ah      = AH_DONE;
                    next_r.rx_byte = bus_in.dio;
                    next_r.oe.nrfd = 1'b1;
                    next_r.oe.ndac = 1'b0;
                    if (!bus_in.atn) begin
                        next_r.push = r.lads;
                    end
                end
            end
            AH_DONE: begin
                // hold NDAC released until the source drops DAV
                if (!bus_in.dav) begin
                    next_r.ah      = acc_on ? AH_NRDY : AH_IDLE;
                    next_r.oe.ndac = acc_on;
                    next_r.oe.nrfd = acc_on;
                end
            end
            default: begin
                next_r.ah = AH_IDLE;
            end
        endcase

        // ---- interface command decode on a freshly accepted byte ----
        if (r.ah == AH_READY && next_r.ah == AH_DONE && bus_in.atn) begin
            if (is_mla) begin
                next_r.lads = 1'b1;
                next_r.tads = 1'b0;
                if (bus_in.ren) begin
                    next_r.rem = 1'b1;
                end
            end
            if (is_unl) begin
                next_r.lads = 1'b0;
            end
            if (is_mta) begin
                next_r.tads = 1'b1;
                next_r.lads = 1'b0;
            end
            if (is_unt || is_ota) begin
                next_r.tads = 1'b0;
            end
            case (cmd)
                CMD_LLO: begin
                    next_r.llo = bus_in.ren;
                end
                CMD_DCL: begin
                    next_r.clr = 1'b1;
                end
                CMD_SDC: begin
                    next_r.clr = r.lads;
                end
                CMD_GTL: begin
                    if (r.lads) begin
                        next_r.rem = 1'b0;
                    end
                end
                CMD_GET: begin
                    next_r.trig = r.lads && (trig_mode == get_trigger_mode_first
                                  || trig_mode == get_trigger_mode_second);
                end
                CMD_SPE: begin
                    next_r.spms = 1'b1;
                end
                CMD_SPD: begin
                    next_r.spms = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // ---- source handshake ----
        case (r.sh)
            SH_IDLE: begin
                next_r.oe.dio = '0;
                next_r.oe.eoi = 1'b0;
                next_r.oe.dav = 1'b0;
                if (src_on && (r.spms || tx_valid)) begin
                    next_r.sh        = SH_SETUP;
                    next_r.poll_byte = r.spms;
                    next_r.oe.dio    = '1;
                    if (r.spms) begin
                        next_r.drv.dio          = status_byte;
                        next_r.drv.dio[RSV_BIT] = r.srq_pend;
                        next_r.oe.eoi           = 1'b0;
                    end else begin
                        next_r.drv.dio = tx_word.data;
                        next_r.oe.eoi  = tx_word.last;
                    end
                end
            end
            SH_SETUP: begin
                // one cycle of settling before DAV, and only once all are ready
                if (!src_on) begin
                    next_r.sh = SH_IDLE;
                end else if (!bus_in.nrfd) begin
                    next_r.sh     = SH_DAV;
                    next_r.oe.dav = 1'b1;
                end
            end
            SH_DAV: begin
                if (!src_on) begin
                    next_r.sh     = SH_IDLE;
                    next_r.oe.dav = 1'b0;
                end else if (!bus_in.ndac) begin
                    next_r.sh      = SH_HOLD;
                    next_r.oe.dav  = 1'b0;
                    next_r.tx_done = !r.poll_byte;
                end
            end
            SH_HOLD: begin
                // byte is gone; release data lines before the next one
                next_r.sh     = SH_IDLE;
                next_r.oe.dio = '0;
                next_r.oe.eoi = 1'b0;
            end
            default: begin
                next_r.sh = SH_IDLE;
            end
        endcase

        // polled request clears on delivery; a new request wins the same cycle
        if (r.sh == SH_DAV && next_r.sh == SH_HOLD && r.poll_byte) begin
            next_r.srq_pend = 1'b0;
        end
        if (service_req) begin
            next_r.srq_pend = 1'b1;
        end
        next_r.oe.srq = next_r.srq_pend;

        // ---- front panel return to local, refused under lockout ----
        if (panel_local && !r.llo) begin
            next_r.rem = 1'b0;
        end

        // ---- REN false drops remote and lockout ----
        if (!bus_in.ren) begin
            next_r.rem = 1'b0;
            next_r.llo = 1'b0;
        end

        // ---- interface clear overrides addressing ----
        if (bus_in.ifc) begin
            next_r.tads   = 1'b0;
            next_r.lads   = 1'b0;
            next_r.spms   = 1'b0;
            next_r.sh     = SH_IDLE;
            next_r.ah     = AH_IDLE;
            next_r.push   = 1'b0;
            next_r.oe.dio = '0;
            next_r.oe.dav = 1'b0;
            next_r.oe.eoi = 1'b0;
            next_r.oe.nrfd = 1'b0;
            next_r.oe.ndac = 1'b0;
        end

        // drivers are open-collector: the asserted value is constant
        next_r.drv.dav  = 1'b1;
        next_r.drv.nrfd = 1'b1;
        next_r.drv.ndac = 1'b1;
        next_r.drv.eoi  = 1'b1;
        next_r.drv.srq  = 1'b1;
        // panel usable only in local; lockout alone does not disable it
        next_r.pnl = !next_r.rem;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r         <= '0;
            r.ah      <= AH_IDLE;
            r.sh      <= SH_IDLE;
            r.rx_byte <= BYTE_RESET;
            r.pnl     <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign bus_out          = r.drv;
    assign bus_oe           = r.oe;
    assign tx_ready         = r.tx_done;
    assign panel_enable     = r.pnl;
    assign talk_addressed   = r.tads;
    assign listen_addressed = r.lads;
    assign remote           = r.rem;
    assign lockout          = r.llo;
    assign dev_clear        = r.clr;
    assign reading_start    = r.trig;

endmodule // bus_ifunc

// File: testbench/ctrl_model.sv
`timescale 1ns/100ps
// ---------------------------------------
// bus controller model, logical levels
// ---------------------------------------
module ctrl_model (
    // clock
    input  wire logic                sys_clk,
    // device side of the bus
    input  wire ifunc_pkg::bus_drv_t bus_out,
    input  wire ifunc_pkg::bus_drv_t bus_oe,
    output ifunc_pkg::bus_in_t       bus_in
);
    import ifunc_pkg::*;
    logic [7:0] c_dio = 8'h00;
    logic       c_dav = 0, c_nrfd = 0, c_ndac = 0, c_atn = 0, c_ren = 0, c_ifc = 0;
    bus_drv_t   d;
    // open-collector wire: a released line reads false through its pull-up
    assign d = bus_drv_t'(bus_oe & bus_out);
    assign bus_in = {d.dio | c_dio, d.dav | c_dav, d.nrfd | c_nrfd, d.ndac | c_ndac,
                     d.eoi, c_atn, c_ren, c_ifc, d.srq};
    // remote enable first, dropped again to cancel lockout
    task automatic ren_set(input logic r);
        @(posedge sys_clk);
        c_ren <= r;
    endtask
    // interface clear held for its full 100 us
    task automatic ifc_pulse;
        @(posedge sys_clk);
        c_ifc <= 1'b1;
        repeat (4000) @(posedge sys_clk);
        c_ifc <= 1'b0;
    endtask
    // source one byte; ok low when no acceptor got ready in time
    task automatic send(input logic [7:0] b, input logic a, output logic ok);
        int i;
        @(posedge sys_clk);
        c_atn <= a;
        c_dio <= b;
        // settle so acceptors react to attention before the ready test
        repeat (3) @(posedge sys_clk);
        for (i = 0; i < 40 && bus_in.nrfd; i++) @(posedge sys_clk);
        ok = !bus_in.nrfd;
        if (ok) begin
            c_dav <= 1'b1;
            @(posedge sys_clk);
            for (i = 0; i < 40 && bus_in.ndac; i++) @(posedge sys_clk);
            c_dav <= 1'b0;
            @(posedge sys_clk);
        end
        c_dio <= 8'h00;
    endtask
    // slow listener: drops attention, stalls, then accepts one byte
    task automatic take(output logic [7:0] b, output logic e);
        int i;
        @(posedge sys_clk);
        {c_atn, c_nrfd, c_ndac} <= 3'b011;
        repeat (4) @(posedge sys_clk);
        c_nrfd <= 1'b0;
        for (i = 0; i < 60 && !bus_in.dav; i++) @(posedge sys_clk);
        {b, e} = {bus_in.dio, bus_in.eoi};
        {c_nrfd, c_ndac} <= 2'b10;
        @(posedge sys_clk);
        for (i = 0; i < 20 && bus_in.dav; i++) @(posedge sys_clk);
        c_nrfd <= 1'b0;
    endtask
endmodule // ctrl_model

// File: testbench/ifunc_chk_sva.sv
`timescale 1ns/100ps
// ---------------------------------------
// interface function protocol checks
// ---------------------------------------
module ifunc_chk (
    // clock, reset, bus and configuration
    input wire logic                  sys_clk, sys_rst, talk_only,
    input wire ifunc_pkg::bus_in_t    bus_in,
    input wire ifunc_pkg::bus_drv_t   bus_oe,
    input wire ifunc_pkg::trig_mode_t trig_mode,
    // state and events
    input wire logic                  talk_addressed, listen_addressed, remote, lockout,
    input wire logic                  dev_clear, reading_start
);
    import ifunc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_clr_end;
        !dev_clear;
    endsequence
    chk_talk_gate: assert property (bus_oe.dav |-> talk_addressed || talk_only)
        else $error("dav driven while not talking");
    chk_addr_excl: assert property (!(talk_addressed && listen_addressed))
        else $error("talker and listener at once");
    chk_dav_pace: assert property ($rose(bus_oe.dav) |-> !$past(bus_in.nrfd))
        else $error("dav raised before ready");
    chk_dav_hold: assert property ($fell(bus_oe.dav) |->
        !$past(bus_in.ndac) || $past(bus_in.atn) || $past(bus_in.ifc))
        else $error("dav dropped before accepted");
    chk_ndac_wait: assert property ($rose(bus_oe.ndac) |-> !$past(bus_in.dav))
        else $error("ndac asserted while dav true");
    chk_ifc_idle: assert property (bus_in.ifc |=>
        !talk_addressed && !listen_addressed && !bus_oe.dav)
        else $error("not idle after clear");
    chk_ren_drop: assert property (!bus_in.ren |=> !remote && !lockout)
        else $error("remote kept without ren");
    chk_remote_ren: assert property ($rose(remote) |-> $past(bus_in.ren))
        else $error("remote without ren");
    chk_trig_mode: assert property (reading_start |->
        trig_mode inside {get_trigger_mode_first, get_trigger_mode_second})
        else $error("reading in wrong mode");
    chk_clr_pulse: assert property (dev_clear |-> $past(bus_in.atn) ##1 s_clr_end)
        else $error("bad clear pulse");
endmodule // ifunc_chk
bind bus_ifunc ifunc_chk chk_u (.sys_clk, .sys_rst, .talk_only, .bus_in, .bus_oe, .trig_mode,
    .talk_addressed, .listen_addressed, .remote, .lockout, .dev_clear, .reading_start);

// File: testbench/bus_ifunc_tb_top.sv
`timescale 1ns/100ps
module bus_ifunc_tb_top;
    import ifunc_pkg::*;
    // ---------------------------------------
    // clock, reset and wiring
    // ---------------------------------------
    logic       sys_clk = 0, sys_rst = 1, tx_valid = 0, rx_ready = 0, service_req = 0;
    logic       panel_local = 0, tx_ready, rx_valid, panel_enable, remote, lockout, ok, e;
    logic       talk_only = 0, talk_addressed, listen_addressed, dev_clear, reading_start;
    logic [7:0] rx_data, b;
    trig_mode_t trig_mode = TRIG_CONT;
    tx_word_t   tx_word = '0;
    bus_in_t    bus_in;
    bus_drv_t   bus_out, bus_oe;
    int         err_count = 0, num_checks = 0, clr_n = 0, trg_n = 0, tx_n = 0, i, k, n;
    localparam logic [7:0] MLA = 8'h3e, MTA = 8'h5e;
    always #12.5 sys_clk = ~sys_clk;
    // pulses are counted so a scenario compares deltas
    always @(posedge sys_clk) begin
        clr_n += dev_clear;
        trg_n += reading_start;
        tx_n += tx_ready;
    end
    bus_ifunc dut_u (.sys_clk, .sys_rst, .ce(1'b1), .bus_in, .bus_out, .bus_oe,
        .primary_addr(ADDR_MAX), .talk_only, .trig_mode, .tx_valid, .tx_word,
        .tx_ready, .rx_valid, .rx_data, .rx_ready, .service_req, .status_byte(8'h81),
        .panel_local, .panel_enable, .talk_addressed, .listen_addressed, .remote, .lockout,
        .dev_clear, .reading_start);
    ctrl_model cm (.sys_clk, .bus_out, .bus_oe, .bus_in);
    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", s, x, g);
        end
    endtask
    // settle two edges so registered effects have landed
    task automatic cmd(input logic [7:0] c);
        cm.send(c, 1'b1, ok);
        chk("cmd_ok", 1, ok);
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_remote;
        cm.ren_set(1'b1);
        repeat (3) @(posedge sys_clk);
        chk("remote", 0, remote);
        cmd(MLA);
        chk("remote", 1, remote);
        cmd(8'h11);
        chk("lockout", 1, lockout);
        chk("panel", 0, panel_enable);
        @(posedge sys_clk) panel_local <= 1'b1;
        @(posedge sys_clk) panel_local <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("remote", 1, remote);
        cmd(8'h01);
        chk("remote", 0, remote);
        chk("lockout", 1, lockout);
        chk("panel", 1, panel_enable);
        cm.ren_set(1'b0);
        repeat (2) @(posedge sys_clk);
        chk("lockout", 0, lockout);
        $display("t_remote done");
    endtask
    // fill the buffer until it refuses, drain it, then send unaddressed data
    task automatic t_rx;
        for (k = 0; k < 9; k++) begin
            cm.send(8'ha0 + k[7:0], 1'b0, ok);
            chk("taken", k < 8, ok);
        end
        @(posedge sys_clk) rx_ready <= 1'b1;
        for (k = 0, i = 0; i < 60 && k < 8; i++) begin
            @(posedge sys_clk);
            if (rx_valid === 1'b1) begin
                chk("rx_data", 8'ha0 + k[7:0], rx_data);
                k++;
            end
        end
        @(posedge sys_clk) rx_ready <= 1'b0;
        chk("drained", 8, k);
        cmd(8'h3f);
        cm.send(8'h55, 1'b0, ok);
        repeat (4) @(posedge sys_clk);
        chk("rx_valid", 0, rx_valid);
        $display("t_rx done");
    endtask
    task automatic t_talk;
        cmd(MTA);
        chk("listen", 0, listen_addressed);
        n = tx_n;
        tx_word <= '{data: 8'hc3, last: 1'b1};
        tx_valid <= 1'b1;
        cm.take(b, e);
        tx_valid <= 1'b0;
        chk("tx_data", 8'hc3, b);
        chk("eoi", 1, e);
        cmd(MLA);
        chk("talk", 0, talk_addressed);
        chk("tx_ready", n + 1, tx_n);
        @(posedge sys_clk) service_req <= 1'b1;
        @(posedge sys_clk) service_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("srq", 1, bus_oe.srq);
        cmd(8'h18);
        cmd(MTA);
        cm.take(b, e);
        chk("status", 8'hc1, b);
        cmd(8'h19);
        chk("srq", 0, bus_oe.srq);
        chk("poll_tx", n + 1, tx_n);
        cm.ifc_pulse();
        repeat (2) @(posedge sys_clk);
        chk("idle", 0, {talk_addressed, listen_addressed});
        $display("t_talk done");
    endtask
    task automatic t_clear;
        n = clr_n;
        cmd(8'h14);
        chk("dcl", n + 1, clr_n);
        cmd(8'h04);
        chk("sdc_idle", n + 1, clr_n);
        cmd(MLA);
        cmd(8'h04);
        chk("sdc", n + 2, clr_n);
        for (k = 0; k < 4; k++) begin
            trig_mode <= trig_mode_t'(k);
            n = trg_n;
            cmd(8'h08);
            chk("trigger", n + (k == 1 || k == 2), trg_n);
        end
        $display("t_clear done");
    endtask
    // unlisten first so the block does not accept its own talk-only byte
    task automatic t_tonly;
        cmd(8'h3f);
        n = tx_n;
        @(posedge sys_clk) talk_only <= 1'b1;
        tx_word <= '{data: 8'h5a, last: 1'b0};
        tx_valid <= 1'b1;
        cm.take(b, e);
        tx_valid <= 1'b0;
        talk_only <= 1'b0;
        chk("tonly_data", 8'h5a, b);
        chk("tonly_eoi", 0, e);
        @(posedge sys_clk);
        chk("tonly_ready", n + 1, tx_n);
        $display("t_tonly done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_remote();
        t_rx();
        t_talk();
        t_clear();
        t_tonly();
        give_verdict();
    end
    // the run needs about 4500 cycles
    initial begin
        #(25 * 30000);
        err_count++;
        give_verdict();
    end
endmodule // bus_ifunc_tb_top
